/* File: common/swe_pkg.sv */
/*
 * Constants of the switching output evaluator: register map, field layout,
 * factory defaults and sizes.
 * Assumes a 32-bit APB with byte addresses and one aligned word per register.
 */
package swe_pkg;
    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int N_WIN      = 16;
    localparam int N_OUT      = 4;
    localparam int N_COL      = 4;
    localparam int N_SEL_PINS = 3;
    localparam int TASK_W     = 4;
    localparam int HIT_W      = 9;
    localparam int SUM_W      = 13;
    localparam int DEPTH_W    = 8;
    localparam int CFG_WORDS  = N_WIN + N_OUT + N_OUT * N_COL;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_WIN_OK   = 12'h008;
    localparam logic [11:0] ADDR_CFG_BASE = 12'h100;
    localparam int          IDX_WIN       = 0;
    localparam int          IDX_SETUP     = 16;
    localparam int          IDX_COL       = 20;

    // ------------------------------------------------------------------
    // control register bits (bits 9..12 are write-one pulses)
    // ------------------------------------------------------------------
    localparam int CTRL_EXT_SEL  = 0;
    localparam int CTRL_SINGLE   = 1;
    localparam int CTRL_TASK_LSB = 4;
    localparam int CTRL_MEAS_REQ = 9;
    localparam int CTRL_STORE    = 10;
    localparam int CTRL_APPLY    = 11;
    localparam int CTRL_FACTORY  = 12;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int STAT_OUT_LSB  = 0;
    localparam int STAT_TASK_LSB = 4;
    localparam int STAT_STORING  = 8;
    localparam int STAT_ARMED    = 9;
    localparam int STAT_VALID    = 10;

    // ------------------------------------------------------------------
    // config word layouts
    // ------------------------------------------------------------------
    localparam int WIN_ON_LSB     = 0;
    localparam int WIN_OFF_LSB    = 16;
    localparam int SET_ACT_BIT    = 0;
    localparam int SET_NEG_BIT    = 1;
    localparam int SET_SUM_BIT    = 2;
    localparam int SET_DEPTH_LSB  = 4;
    localparam int SET_SON_LSB    = 12;
    localparam int SET_SOFF_LSB   = 21;
    localparam int COL_SEL_LSB    = 0;
    localparam int COL_NEG_LSB    = 16;

    // ------------------------------------------------------------------
    // factory defaults: active, depth 1, sum on 10, sum off 6
    // ------------------------------------------------------------------
    localparam logic [31:0] WIN_DFLT   = 32'h0000_0001;
    localparam logic [31:0] SETUP_DFLT = 32'h00C0_A011;
    localparam logic [31:0] COL_DFLT   = 32'h0000_0000;
    localparam logic [31:0] CTRL_DFLT  = 32'h0000_0000;

    // ------------------------------------------------------------------
    // store sequencer
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        SWE_ST_IDLE  = 1'b0,
        SWE_ST_STORE = 1'b1
    } swe_store_t;
endpackage : swe_pkg

/* File: verilog/swe_evaluator.sv */
/*
 * Switching output evaluator: window hysteresis, logical or summation
 * combination, depth filter, task selection and parameter commands.
 * Assumes hit counts and the trigger come from logic on pclk; the task
 * select pins are asynchronous; the nonvolatile store answers with a
 * done pulse.
 */
// Our own choices: register access over APB and the register offsets.
// Behaviour
// - sum skips negated or unused windows
// - sum uses only first column
// - sum at or above on: output one
// - sum at or below off: output zero
// - between thresholds keep previous output
// - external select: task from pins or fieldbus
// - fieldbus may pick tasks 0 to 15
// - external select overrides internal task choice
// - single shot: one analysis per request
// - sixteen windows with own results
// - four independent switching outputs
// - window count versus limits with hysteresis
// - column AND of selected, negated windows
// - OR of four column results
// - optional inversion of OR result
// - store command writes all tasks nonvolatile
// - apply command uses settings immediately
// - factory reset restores all defaults
// - toggle after depth identical evaluations
// - per output method logical or sum
`timescale 1ns/10ps
module swe_evaluator #(
    parameter int N_WIN = swe_pkg::N_WIN,
    parameter int N_OUT = swe_pkg::N_OUT
) (
    // clock, reset, enable
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             ce,
    // apb slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [11:0]                      paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // profile analysis
    input  wire logic [N_WIN*swe_pkg::HIT_W-1:0]  hit_counts,
    input  wire logic                             eval_trig,
    // task selection
    input  wire logic [swe_pkg::N_SEL_PINS-1:0]   task_select_inputs,
    input  wire logic                             fieldbus_sel_valid,
    input  wire logic [swe_pkg::TASK_W-1:0]       fieldbus_task,
    output logic      [swe_pkg::TASK_W-1:0]       active_task,
    // nonvolatile store
    output logic                                  permanent_store_cmd,
    input  wire logic                             nv_store_done,
    // results
    output logic      [N_OUT-1:0]                 switch_output,
    output logic                                  eval_done
);
    localparam int NCFG = swe_pkg::CFG_WORDS;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] cfg_default(input int idx);
        if (idx < swe_pkg::IDX_SETUP) begin
            return swe_pkg::WIN_DFLT;
        end else if (idx < swe_pkg::IDX_COL) begin
            return swe_pkg::SETUP_DFLT;
        end
        return swe_pkg::COL_DFLT;
    endfunction : cfg_default

    // empty column gives 0, never forcing the OR
    function automatic logic column_and(input logic [31:0] col, input logic [15:0] ok);
        logic [15:0] sel;
        logic [15:0] neg;
        sel = col[swe_pkg::COL_SEL_LSB +: 16];
        neg = col[swe_pkg::COL_NEG_LSB +: 16];
        return (sel != 16'h0000) && ((((ok ^ neg) & sel) | ~sel) == 16'hFFFF);
    endfunction : column_and

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic        wr_acc;
    logic        rd_hit_cfg;
    logic [11:0] cfg_off;
    logic [5:0]  cfg_idx;
    logic        cfg_hit;
    logic        ctrl_wr;

    assign pready     = ce;
    assign wr_acc     = psel && penable && pwrite && ce;
    assign cfg_off    = paddr - swe_pkg::ADDR_CFG_BASE;
    assign cfg_idx    = cfg_off[7:2];
    assign rd_hit_cfg = (paddr >= swe_pkg::ADDR_CFG_BASE) && (paddr[1:0] == 2'b00)
                        && (cfg_off[11:2] < 10'(NCFG));
    assign cfg_hit    = rd_hit_cfg;
    assign ctrl_wr    = wr_acc && (paddr == swe_pkg::ADDR_CTRL);

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            pslverr = !(cfg_hit || paddr == swe_pkg::ADDR_CTRL
                        || paddr == swe_pkg::ADDR_STATUS || paddr == swe_pkg::ADDR_WIN_OK);
        end
    end

    // ------------------------------------------------------------------
    // control register and command pulses
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic        cmd_store;
    logic        cmd_apply;
    logic        cmd_factory;
    logic        cmd_meas;

    assign cmd_store   = ctrl_wr && pwdata[swe_pkg::CTRL_STORE];
    assign cmd_apply   = ctrl_wr && pwdata[swe_pkg::CTRL_APPLY];
    assign cmd_factory = ctrl_wr && pwdata[swe_pkg::CTRL_FACTORY];
    assign cmd_meas    = ctrl_wr && pwdata[swe_pkg::CTRL_MEAS_REQ];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= swe_pkg::CTRL_DFLT;
        end else if (ce) begin
            if (cmd_factory) begin
                ctrl_q <= swe_pkg::CTRL_DFLT;
            end else if (ctrl_wr) begin
                ctrl_q <= {24'h000000, pwdata[7:4], 2'b00, pwdata[1:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // staged and active parameter sets
    // ------------------------------------------------------------------
    logic [31:0] stg_q [NCFG];
    logic [31:0] act_q [NCFG];

    // evaluator sees only the applied copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCFG; i++) begin
                stg_q[i] <= cfg_default(i);
                act_q[i] <= cfg_default(i);
            end
        end else if (ce) begin
            for (int i = 0; i < NCFG; i++) begin
                if (cmd_factory) begin
                    stg_q[i] <= cfg_default(i);
                    act_q[i] <= cfg_default(i);
                end else begin
                    if (wr_acc && cfg_hit && cfg_idx == 6'(i)) begin
                        stg_q[i] <= pwdata;
                    end
                    if (cmd_apply) begin
                        act_q[i] <= stg_q[i];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // nonvolatile store sequencer
    // ------------------------------------------------------------------
    swe_pkg::swe_store_t st_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= swe_pkg::SWE_ST_IDLE;
        end else if (ce) begin
            unique case (st_q)
                swe_pkg::SWE_ST_IDLE: begin
                    if (cmd_store && !cmd_factory) begin
                        st_q <= swe_pkg::SWE_ST_STORE;
                    end
                end
                swe_pkg::SWE_ST_STORE: begin
                    if (nv_store_done) begin
                        st_q <= swe_pkg::SWE_ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign permanent_store_cmd = (st_q == swe_pkg::SWE_ST_STORE);

    // ------------------------------------------------------------------
    // task selection
    // ------------------------------------------------------------------
    logic [2:0] sel_s1_q;
    logic [2:0] sel_s2_q;
    logic [2:0] sel_s3_q;
    logic [2:0] sel_q;
    logic [3:0] task_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_s1_q <= 3'h0;
            sel_s2_q <= 3'h0;
            sel_s3_q <= 3'h0;
            sel_q    <= 3'h0;
        end else if (ce) begin
            sel_s1_q <= task_select_inputs;
            sel_s2_q <= sel_s1_q;
            sel_s3_q <= sel_s2_q;
            if (sel_s2_q == sel_s3_q) begin
                sel_q <= sel_s3_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            task_q <= 4'h0;
        end else if (ce) begin
            if (ctrl_q[swe_pkg::CTRL_EXT_SEL]) begin
                if (fieldbus_sel_valid) begin
                    task_q <= fieldbus_task;
                // pins give tasks 0 to 7
                end else begin
                    task_q <= {1'b0, sel_q};
                end
            end else begin
                task_q <= ctrl_q[swe_pkg::CTRL_TASK_LSB +: 4];
            end
        end
    end

    assign active_task = task_q;

    // ------------------------------------------------------------------
    // evaluation strobe
    // ------------------------------------------------------------------
    logic armed_q;
    logic do_eval;

    assign do_eval = eval_trig && (!ctrl_q[swe_pkg::CTRL_SINGLE] || armed_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
        end else if (ce) begin
            // a new request beats consumption
            if (cmd_meas) begin
                armed_q <= 1'b1;
            end else if (do_eval) begin
                armed_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eval_done <= 1'b0;
        end else if (ce) begin
            eval_done <= do_eval;
        end
    end

    // ------------------------------------------------------------------
    // window results
    // ------------------------------------------------------------------
    logic [15:0] win_ok_q;

    generate
        for (genvar w = 0; w < N_WIN; w++) begin : g_win
            logic [8:0] cnt;
            logic [8:0] lim_on;
            logic [8:0] lim_off;
            assign cnt     = hit_counts[w*swe_pkg::HIT_W +: swe_pkg::HIT_W];
            assign lim_on  = act_q[swe_pkg::IDX_WIN + w][swe_pkg::WIN_ON_LSB +: 9];
            assign lim_off = act_q[swe_pkg::IDX_WIN + w][swe_pkg::WIN_OFF_LSB +: 9];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    win_ok_q[w] <= 1'b0;
                end else if (ce && do_eval) begin
                    if (cnt >= lim_on) begin
                        win_ok_q[w] <= 1'b1;
                    end else if (cnt <= lim_off) begin
                        win_ok_q[w] <= 1'b0;
                    end
                end
            end
        end
        for (genvar w = N_WIN; w < 16; w++) begin : g_win_pad
            assign win_ok_q[w] = 1'b0;
        end
    endgenerate

    // ------------------------------------------------------------------
    // switching outputs
    // ------------------------------------------------------------------
    logic        valid_q;
    logic [15:0] ok_now;

    // combine on this evaluation's window results
    generate
        for (genvar w = 0; w < 16; w++) begin : g_ok
            if (w < N_WIN) begin : g_real
                always_comb begin
                    ok_now[w] = win_ok_q[w];
                    if (g_win[w].cnt >= g_win[w].lim_on) begin
                        ok_now[w] = 1'b1;
                    end else if (g_win[w].cnt <= g_win[w].lim_off) begin
                        ok_now[w] = 1'b0;
                    end
                end
            end else begin : g_none
                assign ok_now[w] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= 1'b0;
        end else if (ce && do_eval) begin
            valid_q <= 1'b1;
        end
    end

    generate
        for (genvar o = 0; o < N_OUT; o++) begin : g_out
            logic [31:0]      setup;
            logic [31:0]      col0;
            logic [3:0]       col_res;
            logic             logic_res;
            logic [12:0]      sum;
            logic             sum_st_q;
            logic             sum_res;
            logic             raw;
            logic             last_q;
            logic [7:0]       cnt_q;
            logic [7:0]       cnt_d;
            logic [7:0]       depth;
            logic             out_q;

            assign setup = act_q[swe_pkg::IDX_SETUP + o];
            assign col0  = act_q[swe_pkg::IDX_COL + o * swe_pkg::N_COL];
            assign depth = setup[swe_pkg::SET_DEPTH_LSB +: 8];

            for (genvar c = 0; c < swe_pkg::N_COL; c++) begin : g_col
                assign col_res[c] =
                    column_and(act_q[swe_pkg::IDX_COL + o * swe_pkg::N_COL + c], ok_now);
            end
            assign logic_res = (|col_res) ^ setup[swe_pkg::SET_NEG_BIT];

            always_comb begin
                sum = 13'h0000;
                for (int w = 0; w < N_WIN; w++) begin
                    if (col0[swe_pkg::COL_SEL_LSB + w] && !col0[swe_pkg::COL_NEG_LSB + w]) begin
                        sum = sum + 13'(hit_counts[w*swe_pkg::HIT_W +: swe_pkg::HIT_W]);
                    end
                end
            end

            always_comb begin
                sum_res = sum_st_q;
                if (sum >= 13'(setup[swe_pkg::SET_SON_LSB +: 9])) begin
                    sum_res = 1'b1;
                end else if (sum <= 13'(setup[swe_pkg::SET_SOFF_LSB +: 9])) begin
                    sum_res = 1'b0;
                end
            end

            assign raw = setup[swe_pkg::SET_SUM_BIT] ? sum_res : logic_res;

            always_comb begin
                cnt_d = 8'h01;
                if (valid_q && raw == last_q) begin
                    cnt_d = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sum_st_q <= 1'b0;
                    last_q   <= 1'b0;
                    cnt_q    <= 8'h00;
                    out_q    <= 1'b0;
                end else if (ce && do_eval) begin
                    sum_st_q <= sum_res;
                    last_q   <= raw;
                    cnt_q    <= cnt_d;
                    if (cnt_d >= depth) begin
                        out_q <= raw;
                    end
                end
            end

            assign switch_output[o] = out_q && setup[swe_pkg::SET_ACT_BIT];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [3:0] out_pad;

    assign out_pad = 4'(switch_output);

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            if (paddr == swe_pkg::ADDR_CTRL) begin
                prdata = ctrl_q;
            end else if (paddr == swe_pkg::ADDR_STATUS) begin
                prdata[swe_pkg::STAT_OUT_LSB +: 4]  = out_pad;
                prdata[swe_pkg::STAT_TASK_LSB +: 4] = task_q;
                prdata[swe_pkg::STAT_STORING]       = permanent_store_cmd;
                prdata[swe_pkg::STAT_ARMED]         = armed_q;
                prdata[swe_pkg::STAT_VALID]         = valid_q;
            end else if (paddr == swe_pkg::ADDR_WIN_OK) begin
                prdata[15:0] = win_ok_q;
            end else if (cfg_hit) begin
                prdata = stg_q[cfg_idx];
            end
        end
    end
endmodule : swe_evaluator

/* File: verification/swe_evaluator_properties.sv */
/* port checker of the evaluator.
   bound to swe_evaluator in the bench top; ce is expected high. */
`timescale 1ns/10ps
module swe_evaluator_properties (
    // clock and bus
    input wire logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // results and store
    input wire logic        eval_trig, eval_done, permanent_store_cmd, nv_store_done,
    input wire logic [3:0]  switch_output
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic map_hit;
    logic store_wr;
    assign map_hit = paddr inside {12'h000, 12'h004, 12'h008}
        || (paddr >= 12'h100 && paddr <= 12'h18C && paddr[1:0] == 2'h0);
    // factory beats store
    assign store_wr = psel && penable && pwrite && ce && paddr == swe_pkg::ADDR_CTRL
        && pwdata[10] && !pwdata[12];
    chk_ready_ce: assert property (pready == ce) else $error("pready not ce");
    chk_err_unmapped: assert property (psel && penable && !map_hit |-> pslverr)
        else $error("no slverr");
    chk_done_cause: assert property (eval_done |-> $past(eval_trig && ce))
        else $error("done without trigger");
    chk_out_cause: assert property ($changed(switch_output)
        |-> $past(eval_trig || (psel && pwrite))) else $error("output moved alone");
    chk_reset_quiet: assert property ($past(!presetn)
        |-> switch_output == 4'h0 && !eval_done) else $error("busy after reset");
    chk_store_start: assert property (store_wr && !permanent_store_cmd
        |-> ##[1:2] permanent_store_cmd) else $error("store not started");
    chk_store_hold: assert property (permanent_store_cmd && !nv_store_done
        && !$past(nv_store_done) |=> permanent_store_cmd) else $error("store dropped");
    chk_store_end: assert property (permanent_store_cmd && nv_store_done
        |-> ##[1:2] !permanent_store_cmd) else $error("store not ended");
endmodule : swe_evaluator_properties

/* File: verification/swe_store_model.sv */
/* nonvolatile store model: answers each store command with one done pulse.
   lat sets the answer delay in cycles; held stable per command. */
`timescale 1ns/10ps
module swe_store_model (
    input wire logic       pclk, presetn, permanent_store_cmd,
    input wire logic [3:0] lat,
    output logic           nv_store_done
);
    logic [3:0] cnt_q;
    logic       busy_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
            nv_store_done <= 1'b0;
        end else begin
            nv_store_done <= 1'b0;
            if (!permanent_store_cmd) begin
                cnt_q <= 4'h0;
                busy_q <= 1'b0;
            end else if (!busy_q && cnt_q == lat) begin
                nv_store_done <= 1'b1;
                busy_q <= 1'b1;
            end else if (!busy_q) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : swe_store_model

/* File: verification/test_switching_output_evaluator.sv */
/* bench top: random configs and hits against a reference model.
   needs the checker and store model compiled first. */
`timescale 1ns/10ps
module test_switching_output_evaluator;
    logic         pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, eval_trig = 0;
    logic         fieldbus_sel_valid = 0, pready, pslverr, eval_done, permanent_store_cmd, err;
    logic         nv_store_done;
    logic [11:0]  paddr = 0;
    logic [31:0]  pwdata = 0, prdata, rd, r;
    logic [143:0] hit_counts = 0;
    logic [2:0]   task_select_inputs = 0;
    logic [3:0]   fieldbus_task = 0, active_task, switch_output, lat = 2;
    logic [3:0]   act, ngt, sm, sst = 0, prv = 0, flt = 0;
    logic [8:0]   won[16], woff[16], h[16], son[4], soff[4];
    logic [15:0]  sel[16], neg[16], wok = 0;
    logic [7:0]   dep[4], cnt[4];
    bit           first = 1;
    int           miscompares = 0, comparisons = 0;
    integer       seed = 32'hb96679c1;
    swe_evaluator dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hit_counts, .eval_trig, .task_select_inputs,
        .fieldbus_sel_valid, .fieldbus_task, .active_task, .permanent_store_cmd,
        .nv_store_done, .switch_output, .eval_done);
    swe_store_model nv_u (.pclk, .presetn, .lat, .permanent_store_cmd, .nv_store_done);
    initial forever #5 pclk = ~pclk;
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        give_verdict;
    end
    task automatic give_verdict;
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    // reference model
    task automatic predict;
        int s;
        logic x;
        for (int w = 0; w < 16; w++) if (h[w] >= won[w]) wok[w] = 1; else if (h[w] <= woff[w]) wok[w] = 0;
        for (int o = 0; o < 4; o++) begin
            s = 0;
            x = 0;
            for (int w = 0; w < 16; w++) if (sel[o*4][w] && !neg[o*4][w]) s += h[w];
            if (s >= son[o]) sst[o] = 1; else if (s <= soff[o]) sst[o] = 0;
            for (int c = 0; c < 4; c++)
                x |= sel[o*4+c] != 0 && ((wok ^ neg[o*4+c]) | ~sel[o*4+c]) == 16'hFFFF;
            x = sm[o] ? sst[o] : x ^ ngt[o];
            cnt[o] = (first || x != prv[o]) ? 8'h01 : cnt[o] + (cnt[o] != 8'hFF);
            prv[o] = x;
            if (cnt[o] >= dep[o]) flt[o] = x;
        end
        first = 0;
    endtask : predict
    task automatic ev(input logic e, input logic [3:0] so);
        for (int w = 0; w < 16; w++) hit_counts[w*9 +: 9] <= h[w];
        eval_trig <= 1;
        @(posedge pclk);
        eval_trig <= 0;
        @(negedge pclk);
        cmp("eval_done", e, eval_done);
        cmp("switch_output", so, switch_output);
        @(posedge pclk);
    endtask : ev
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, swe_pkg::ADDR_STATUS, 0);
        cmp("status", 0, rd[10:0]);
        apb(1, 12'h140, 0);
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_1000);
        apb(0, 12'h140, 0);
        cmp("setup", swe_pkg::SETUP_DFLT, rd);
        apb(0, 12'h00C, 0);
        cmp("slverr", 1, err);
        for (int k = 0; k < 16; k++) begin
            r = $random(seed);
            won[k] = 9'd2 + r[1:0];
            woff[k] = won[k] - 9'd2;
            // dense columns keep sums near limits
            sel[k] = r[31:16] & (k[2] ? 16'hFFFF : r[15:0] & 16'($random(seed)));
            neg[k] = 16'($random(seed) & $random(seed));
            apb(1, 12'h100 + 12'(4*k), {7'h0, woff[k], 7'h0, won[k]});
            apb(1, 12'h150 + 12'(4*k), {neg[k], sel[k]});
        end
        for (int o = 0; o < 4; o++) begin
            r = $random(seed);
            act[o] = r[0] | r[1];
            sm[o] = o[0];
            ngt[o] = r[3] & !sm[o];
            dep[o] = 8'(r[5:4]) + 8'h01;
            son[o] = 9'd12 + r[9:6];
            soff[o] = son[o] - 9'd6;
            apb(1, 12'h140 + 12'(4*o), {2'h0, soff[o], son[o], dep[o], 1'b0, sm[o], ngt[o], act[o]});
        end
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_0800);
        repeat (60) begin
            for (int w = 0; w < 16; w++) h[w] = 9'($random(seed) & 7);
            predict;
            ev(1, flt & act);
        end
        apb(0, swe_pkg::ADDR_WIN_OK, 0);
        cmp("win_ok", wok, rd);
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_0002);
        ev(0, flt & act);
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_0202);
        predict;
        ev(1, flt & act);
        ev(0, flt & act);
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_0021);
        fieldbus_sel_valid <= 1;
        fieldbus_task <= 4'hD;
        repeat (3) @(posedge pclk);
        cmp("task", 4'hD, active_task);
        fieldbus_sel_valid <= 0;
        task_select_inputs <= 3'h5;
        repeat (8) @(posedge pclk);
        cmp("task", 4'h5, active_task);
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_0020);
        @(posedge pclk);
        cmp("task", 4'h2, active_task);
        lat <= 4'(2 + ($random(seed) & 7));
        apb(1, swe_pkg::ADDR_CTRL, 32'h0000_0400);
        @(posedge pclk);
        cmp("store", 1, permanent_store_cmd);
        repeat (30) @(posedge pclk);
        cmp("store", 0, permanent_store_cmd);
        give_verdict;
    end
endmodule : test_switching_output_evaluator
bind swe_evaluator swe_evaluator_properties chk_u (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .pready, .pslverr, .paddr, .pwdata, .eval_trig, .eval_done,
    .permanent_store_cmd, .nv_store_done, .switch_output);
